//--- hdl/cid_alu.sv
// accumulator alu: and, add and pass with carry, digit carry and zero
`timescale 1ns/10ps
module cid_alu (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire cid_pkg::cid_alu_op_t op_i,
  output logic [7:0] res_o,
  output logic c_o,
  output logic dc_o,
  output logic z_o
);
  import cid_pkg::*;

  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    sum = {1'b0, a_i} + {1'b0, b_i};
    low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    c_o = sum[8];
    dc_o = low_sum[4];
    case (op_i)
      CID_ALU_AND: res_o = a_i & b_i;
      CID_ALU_ADD: res_o = sum[7:0];
      CID_ALU_PASS: res_o = b_i;
      default: res_o = 8'h00;
    endcase
    z_o = (res_o == 8'h00);
  end
endmodule

//--- hdl/cid_core.sv
// control, inherent, indirect pointer and mask/sum operation core with wishbone status port
`timescale 1ns/10ps
module cid_core (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [cid_pkg::PC_W-1:0] pmem_addr_o,
  input wire logic [cid_pkg::IR_W-1:0] pmem_data_i,
  output logic [cid_pkg::DA_W-1:0] data_addr_o,
  output logic data_re_o,
  output logic data_we_o,
  output logic [7:0] data_wdata_o,
  input wire logic [7:0] data_rdata_i,
  input wire logic wake_i,
  output logic sleep_o,
  output logic gie_o,
  output logic wdt_clear_o,
  output logic soft_reset_o,
  output logic instr_cycle_o,
  input wire logic [cid_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import cid_pkg::*;

  // ==========================================================================
  // state
  cid_phase_t phase_r, phase_nxt;
  logic [IR_W-1:0] ir_r, ir_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt, pmem_addr_r, pmem_addr_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt, to_r, to_nxt, pwrdn_r, pwrdn_nxt;
  logic gie_r, gie_nxt, sleep_r, sleep_nxt;
  logic [DA_W-1:0] ptr_r [2];
  logic [DA_W-1:0] ptr_nxt [2];
  logic [7:0] dir_r [DIR_REGS];
  logic [7:0] dir_nxt [DIR_REGS];
  logic [1:0] bub_r, bub_nxt;
  logic [DA_W-1:0] daddr_r, daddr_nxt;
  logic re_r, re_nxt, we_r, we_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wdt_r, wdt_nxt, srst_r, srst_nxt, icyc_r, icyc_nxt;
  logic run_r, run_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;

  // ==========================================================================
  // decode
  logic is_ofsj, is_accj, is_call, is_acall, is_absj, is_litret, is_ret, is_irqret;
  logic is_srst, is_wdt, is_slp, is_dirld, is_ptradd, is_mi, is_mw, is_mik, is_mwk;
  logic is_litand, is_litsum, is_fileand, file_win, exec_ok, rd_need, wr_need, ind_msb;
  logic ptr_n;
  logic [DA_W-1:0] ptr_cur, ptr_step, k6, acc_addr;
  logic [PC_W-1:0] pc_inc, stack_top;
  logic push, pop, stack_clr;
  cid_alu_op_t alu_op;
  logic [7:0] alu_b, alu_res;
  logic alu_c, alu_dc, alu_z;

  always_comb begin
    is_ofsj = (ir_r[13:9] == OPC_OFFSET_JUMP);
    is_accj = (ir_r == OPC_ACCUM_OFFSET_JUMP);
    is_call = (ir_r[13:11] == OPC_SUBROUTINE_JUMP);
    is_absj = (ir_r[13:11] == OPC_ABSOLUTE_JUMP);
    is_acall = (ir_r == OPC_ACCUM_SUBROUTINE_JUMP);
    is_litret = (ir_r[13:8] == OPC_LITERAL_RETURN);
    is_ret = (ir_r == OPC_PLAIN_RETURN);
    is_irqret = (ir_r == OPC_INTERRUPT_EXIT);
    is_srst = (ir_r == OPC_SOFT_RESET);
    is_wdt = (ir_r == OPC_WATCHDOG_KICK);
    is_slp = (ir_r == OPC_STANDBY);
    is_dirld = (ir_r[13:3] == OPC_PIN_DIRECTION_LOAD);
    is_ptradd = (ir_r[13:7] == OPC_POINTER_OFFSET_ADD);
    is_mi = (ir_r[13:3] == OPC_POINTER_LOAD_ACCUM);
    is_mik = (ir_r[13:7] == OPC_POINTER_LOAD_INDEXED);
    is_mw = (ir_r[13:3] == OPC_ACCUM_STORE_POINTER);
    is_mwk = (ir_r[13:7] == OPC_STORE_POINTER_INDEXED);
    is_litand = (ir_r[13:8] == OPC_LITERAL_MASK_ACCUM);
    is_litsum = (ir_r[13:8] == OPC_LITERAL_SUM_ACCUM);
    is_fileand = (ir_r[13:8] == OPC_FILE_MASK_OP);
    file_win = (ir_r[6:1] == FILE_WINDOW_HI);
    exec_ok = run_r & ~sleep_r & (bub_r == 2'b00);
    ptr_n = (is_mi | is_mw) ? ir_r[2] : ir_r[6];
    if (is_fileand) begin
      ptr_n = ir_r[0];
    end
    ptr_cur = ptr_r[ptr_n];
    k6 = {{10{ir_r[5]}}, ir_r[5:0]};
    ptr_step = ir_r[0] ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001;
    if (is_mi | is_mw) begin
      acc_addr = ir_r[1] ? ptr_cur : ptr_step;
    end else if (is_mik | is_mwk) begin
      acc_addr = ptr_cur + k6;
    end else if (file_win) begin
      acc_addr = ptr_cur;
    end else begin
      acc_addr = {3'h0, bank_r, ir_r[6:0]};
    end
    rd_need = is_mi | is_mik | is_fileand;
    wr_need = is_mw | is_mwk | (is_fileand & ir_r[7]);
    ind_msb = (is_mi | is_mw | is_mik | is_mwk | (is_fileand & file_win)) & ptr_cur[15];
    pc_inc = pc_r + 15'h0001;
    alu_b = (is_litand | is_litsum) ? ir_r[7:0] : data_rdata_i;
    if (is_litsum) begin
      alu_op = CID_ALU_ADD;
    end else if (is_mi | is_mik) begin
      alu_op = CID_ALU_PASS;
    end else begin
      alu_op = CID_ALU_AND;
    end
  end

  cid_alu u_alu (
    .a_i(acc_r),
    .b_i(alu_b),
    .op_i(alu_op),
    .res_o(alu_res),
    .c_o(alu_c),
    .dc_o(alu_dc),
    .z_o(alu_z)
  );

  cid_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(stack_clr),
    .push_i(push),
    .pop_i(pop),
    .data_i(pc_inc),
    .top_o(stack_top)
  );

  // ==========================================================================
  // instruction sequencing and execution
  always_comb begin
    phase_nxt = cid_phase_t'(phase_r + 2'b01);
    ir_nxt = ir_r;
    pc_nxt = pc_r;
    pmem_addr_nxt = pmem_addr_r;
    acc_nxt = acc_r;
    c_nxt = c_r;
    dc_nxt = dc_r;
    z_nxt = z_r;
    to_nxt = to_r;
    pwrdn_nxt = pwrdn_r;
    gie_nxt = gie_r;
    sleep_nxt = sleep_r;
    ptr_nxt = ptr_r;
    dir_nxt = dir_r;
    bub_nxt = bub_r;
    daddr_nxt = daddr_r;
    re_nxt = 1'b0;
    we_nxt = 1'b0;
    wdata_nxt = wdata_r;
    wdt_nxt = 1'b0;
    srst_nxt = 1'b0;
    icyc_nxt = (phase_r == CID_Q3);
    push = 1'b0;
    pop = 1'b0;
    stack_clr = 1'b0;
    case (phase_r)
      CID_Q0: begin
        ir_nxt = pmem_data_i;
      end
      CID_Q1: begin
        if (exec_ok & (rd_need | wr_need)) begin
          daddr_nxt = acc_addr;
          re_nxt = rd_need;
        end
      end
      CID_Q2: begin
        re_nxt = 1'b0;
      end
      CID_Q3: begin
        if (sleep_r) begin
          sleep_nxt = ~wake_i;
        end else if (!run_r) begin
          pc_nxt = pc_r;
        end else if (bub_r != 2'b00) begin
          bub_nxt = bub_r - 2'b01;
        end else begin
          pc_nxt = pc_inc;
          if (is_ofsj) begin
            pc_nxt = pc_inc + {{6{ir_r[8]}}, ir_r[8:0]};
          end else if (is_accj) begin
            pc_nxt = pc_inc + {7'h00, acc_r};
          end else if (is_call | is_absj) begin
            pc_nxt = {pc_r[14:11], ir_r[10:0]};
            push = is_call;
          end else if (is_acall) begin
            pc_nxt = {pc_r[14:8], acc_r};
            push = 1'b1;
          end else if (is_litret | is_ret | is_irqret) begin
            pc_nxt = stack_top;
            pop = 1'b1;
            if (is_litret) begin
              acc_nxt = ir_r[7:0];
            end
            if (is_irqret) begin
              gie_nxt = 1'b1;
            end
          end else if (is_srst) begin
            pc_nxt = PC_RST;
            acc_nxt = ACC_RST;
            ptr_nxt[0] = PTR_RST;
            ptr_nxt[1] = PTR_RST;
            gie_nxt = 1'b0;
            stack_clr = 1'b1;
            srst_nxt = 1'b1;
          end else if (is_wdt | is_slp) begin
            to_nxt = 1'b1;
            pwrdn_nxt = is_wdt;
            wdt_nxt = 1'b1;
            sleep_nxt = is_slp;
          end else if (is_dirld) begin
            dir_nxt[ir_r[2:0]] = acc_r;
          end else if (is_ptradd) begin
            ptr_nxt[ptr_n] = ptr_cur + k6;
          end else if (is_mi | is_mik) begin
            acc_nxt = alu_res;
            z_nxt = alu_z;
          end else if (is_mw | is_mwk) begin
            we_nxt = 1'b1;
            wdata_nxt = acc_r;
          end else if (is_litand) begin
            acc_nxt = alu_res;
            z_nxt = alu_z;
          end else if (is_litsum) begin
            acc_nxt = alu_res;
            c_nxt = alu_c;
            dc_nxt = alu_dc;
            z_nxt = alu_z;
          end else if (is_fileand) begin
            z_nxt = alu_z;
            if (ir_r[7]) begin
              we_nxt = 1'b1;
              wdata_nxt = alu_res;
            end else begin
              acc_nxt = alu_res;
            end
          end
          if (is_mi | is_mw) begin
            ptr_nxt[ptr_n] = ptr_step;
          end
          if (!is_srst) begin
            bub_nxt = {1'b0, is_ofsj | is_accj | is_call | is_acall | is_absj | is_litret | is_ret | is_irqret}
                      + {1'b0, ind_msb};
          end
        end
        pmem_addr_nxt = pc_nxt;
      end
      default: begin
        phase_nxt = CID_Q0;
      end
    endcase
  end

  // ==========================================================================
  // wishbone slave
  always_comb begin
    run_nxt = run_r;
    bank_nxt = bank_r;
    dat_nxt = 32'h0000_0000;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    if (ack_r & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]) begin
      if (wb_adr_i == WB_CTRL) begin
        run_nxt = wb_dat_i[CTRL_RUN_BIT];
      end
      if (wb_adr_i == WB_BANK) begin
        bank_nxt = wb_dat_i[BANK_W-1:0];
      end
    end
    if (ack_nxt & ~wb_we_i) begin
      if (wb_adr_i == WB_CTRL) begin
        dat_nxt[CTRL_RUN_BIT] = run_r;
      end else if (wb_adr_i == WB_STATUS) begin
        dat_nxt[7:0] = acc_r;
        dat_nxt[ST_C_BIT] = c_r;
        dat_nxt[ST_DC_BIT] = dc_r;
        dat_nxt[ST_Z_BIT] = z_r;
        dat_nxt[ST_TO_BIT] = to_r;
        dat_nxt[ST_PWRDN_BIT] = pwrdn_r;
        dat_nxt[ST_SLEEP_BIT] = sleep_r;
        dat_nxt[ST_GIE_BIT] = gie_r;
      end else if (wb_adr_i == WB_PC) begin
        dat_nxt[PC_W-1:0] = pc_r;
      end else if (wb_adr_i == WB_POINTERS) begin
        dat_nxt = {ptr_r[1], ptr_r[0]};
      end else if (wb_adr_i == WB_BANK) begin
        dat_nxt[BANK_W-1:0] = bank_r;
      end else if (wb_adr_i >= WB_DIR_BASE && wb_adr_i <= WB_DIR_LAST && wb_adr_i[1:0] == 2'b00) begin
        dat_nxt[7:0] = dir_r[wb_adr_i[4:2]];
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= CID_Q0;
      ir_r <= OPC_IDLE_SLOT_OP;
      pc_r <= PC_RST;
      pmem_addr_r <= PC_RST;
      acc_r <= ACC_RST;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
      to_r <= TO_RST;
      pwrdn_r <= PWRDN_RST;
      gie_r <= 1'b0;
      sleep_r <= 1'b0;
      ptr_r[0] <= PTR_RST;
      ptr_r[1] <= PTR_RST;
      for (int i = 0; i < DIR_REGS; i++) begin
        dir_r[i] <= DIR_RST;
      end
      bub_r <= 2'b00;
      daddr_r <= PTR_RST;
      re_r <= 1'b0;
      we_r <= 1'b0;
      wdata_r <= 8'h00;
      wdt_r <= 1'b0;
      srst_r <= 1'b0;
      icyc_r <= 1'b0;
      run_r <= CTRL_RUN_RST;
      bank_r <= BANK_RST;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      phase_r <= phase_nxt;
      ir_r <= ir_nxt;
      pc_r <= pc_nxt;
      pmem_addr_r <= pmem_addr_nxt;
      acc_r <= acc_nxt;
      c_r <= c_nxt;
      dc_r <= dc_nxt;
      z_r <= z_nxt;
      to_r <= to_nxt;
      pwrdn_r <= pwrdn_nxt;
      gie_r <= gie_nxt;
      sleep_r <= sleep_nxt;
      ptr_r <= ptr_nxt;
      dir_r <= dir_nxt;
      bub_r <= bub_nxt;
      daddr_r <= daddr_nxt;
      re_r <= re_nxt;
      we_r <= we_nxt;
      wdata_r <= wdata_nxt;
      wdt_r <= wdt_nxt;
      srst_r <= srst_nxt;
      icyc_r <= icyc_nxt;
      run_r <= run_nxt;
      bank_r <= bank_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign pmem_addr_o = pmem_addr_r;
  assign data_addr_o = daddr_r;
  assign data_re_o = re_r;
  assign data_we_o = we_r;
  assign data_wdata_o = wdata_r;
  assign sleep_o = sleep_r;
  assign gie_o = gie_r;
  assign wdt_clear_o = wdt_r;
  assign soft_reset_o = srst_r;
  assign instr_cycle_o = icyc_r;
  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
endmodule

//--- hdl/cid_stack.sv
// hardware return stack held in flip-flops, wraps on overflow
`timescale 1ns/10ps
module cid_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] top_o
);
  import cid_pkg::*;

  localparam int SP_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [SP_W-1:0] sp_nxt;

  always_comb begin
    mem_nxt = mem_r;
    sp_nxt = sp_r;
    if (clr_i) begin
      sp_nxt = '0;
    end else if (push_i) begin
      mem_nxt[sp_r] = data_i;
      sp_nxt = sp_r + SP_W'(1);
    end else if (pop_i) begin
      sp_nxt = sp_r - SP_W'(1);
    end
    top_o = mem_r[sp_r - SP_W'(1)];
  end

  always_ff @(posedge clk_i) begin
    mem_r <= mem_nxt;
    if (rst_i) begin
      sp_r <= '0;
    end else begin
      sp_r <= sp_nxt;
    end
  end
endmodule

//--- pkg/cid_pkg.sv
// shared constants and types of the control and indirect operation decoder
package cid_pkg;

  // ==========================================================================
  // widths
  localparam int PC_W = 15;
  localparam int IR_W = 14;
  localparam int DA_W = 16;
  localparam int BANK_W = 6;
  localparam int STACK_DEPTH = 16;
  localparam int DIR_REGS = 8;
  localparam int WB_AW = 8;

  // ==========================================================================
  // instruction cycle phases
  typedef enum logic [1:0] {
    CID_Q0 = 2'b00,
    CID_Q1 = 2'b01,
    CID_Q2 = 2'b10,
    CID_Q3 = 2'b11
  } cid_phase_t;

  typedef enum logic [1:0] {
    CID_ALU_AND = 2'b00,
    CID_ALU_ADD = 2'b01,
    CID_ALU_PASS = 2'b10
  } cid_alu_op_t;

  // ==========================================================================
  // opcode patterns, compared against the upper bits named in each comment
  localparam logic [4:0] OPC_OFFSET_JUMP = 5'h19;           // ir[13:9]
  localparam logic [2:0] OPC_SUBROUTINE_JUMP = 3'h4;        // ir[13:11]
  localparam logic [2:0] OPC_ABSOLUTE_JUMP = 3'h5;          // ir[13:11]
  localparam logic [5:0] OPC_LITERAL_RETURN = 6'h34;        // ir[13:8]
  localparam logic [5:0] OPC_LITERAL_MASK_ACCUM = 6'h39;    // ir[13:8]
  localparam logic [5:0] OPC_LITERAL_SUM_ACCUM = 6'h3E;     // ir[13:8]
  localparam logic [5:0] OPC_FILE_MASK_OP = 6'h05;          // ir[13:8]
  localparam logic [6:0] OPC_POINTER_OFFSET_ADD = 7'h62;    // ir[13:7]
  localparam logic [6:0] OPC_POINTER_LOAD_INDEXED = 7'h7E;  // ir[13:7]
  localparam logic [6:0] OPC_STORE_POINTER_INDEXED = 7'h7F; // ir[13:7]
  localparam logic [10:0] OPC_PIN_DIRECTION_LOAD = 11'h00C; // ir[13:3]
  localparam logic [10:0] OPC_POINTER_LOAD_ACCUM = 11'h002; // ir[13:3]
  localparam logic [10:0] OPC_ACCUM_STORE_POINTER = 11'h003; // ir[13:3]
  localparam logic [13:0] OPC_IDLE_SLOT_OP = 14'h0000;
  localparam logic [13:0] OPC_SOFT_RESET = 14'h0001;
  localparam logic [13:0] OPC_PLAIN_RETURN = 14'h0008;
  localparam logic [13:0] OPC_INTERRUPT_EXIT = 14'h0009;
  localparam logic [13:0] OPC_ACCUM_SUBROUTINE_JUMP = 14'h000A;
  localparam logic [13:0] OPC_ACCUM_OFFSET_JUMP = 14'h000B;
  localparam logic [13:0] OPC_STANDBY = 14'h0063;
  localparam logic [13:0] OPC_WATCHDOG_KICK = 14'h0064;
  localparam logic [5:0] FILE_WINDOW_HI = 6'h00;            // f[6:1] of both windows

  // ==========================================================================
  // register map (byte offsets)
  localparam logic [WB_AW-1:0] WB_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] WB_STATUS = 8'h04;
  localparam logic [WB_AW-1:0] WB_PC = 8'h08;
  localparam logic [WB_AW-1:0] WB_POINTERS = 8'h0C;
  localparam logic [WB_AW-1:0] WB_BANK = 8'h10;
  localparam logic [WB_AW-1:0] WB_DIR_BASE = 8'h20;
  localparam logic [WB_AW-1:0] WB_DIR_LAST = 8'h3C;

  // status field positions
  localparam int ST_C_BIT = 8;
  localparam int ST_DC_BIT = 9;
  localparam int ST_Z_BIT = 10;
  localparam int ST_TO_BIT = 11;
  localparam int ST_PWRDN_BIT = 12;
  localparam int ST_SLEEP_BIT = 13;
  localparam int ST_GIE_BIT = 14;
  localparam int CTRL_RUN_BIT = 0;

  // ==========================================================================
  // values after reset
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  localparam logic PWRDN_RST = 1'b1;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [DA_W-1:0] PTR_RST = 16'h0000;
  localparam logic [BANK_W-1:0] BANK_RST = 6'h00;

endpackage

//--- verif/cid_core_bench.sv
// self-checking bench for the decoder core
`timescale 1ns/10ps
module cid_core_bench;
  import cid_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wake_i = 1'b0;
  logic [WB_AW-1:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [PC_W-1:0] pmem_addr_o;
  logic [IR_W-1:0] pmem_data_i;
  logic [DA_W-1:0] data_addr_o;
  logic data_re_o, data_we_o, sleep_o, gie_o, soft_reset_o, instr_cycle_o, wb_ack_o;
  logic [7:0] data_wdata_o, data_rdata_i, k1, k2, k3, k4, a3, fm;
  logic [31:0] wb_dat_o, q;
  logic [31:0] seed = 32'hb0b39be5;
  logic [8:0] s2;
  logic dc2;
  logic [5:0] bank;
  logic [15:0] fa;
  int n_fail = 0;
  int n_compared = 0;
  int n_cyc = 0;
  int n_clk = 0;
  cid_core DUT (.clk_i, .rst_i, .pmem_addr_o, .pmem_data_i, .data_addr_o, .data_re_o, .data_we_o,
    .data_wdata_o, .data_rdata_i, .wake_i, .sleep_o, .gie_o, .wdt_clear_o(), .soft_reset_o, .instr_cycle_o,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);
  cid_mem_model PM (.clk_i(clk_i), .pmem_addr_i(pmem_addr_o), .pmem_data_o(pmem_data_i),
    .data_addr_i(data_addr_o), .data_re_i(data_re_o), .data_we_i(data_we_o),
    .data_wdata_i(data_wdata_o), .data_rdata_o(data_rdata_i));
  // ==========================================================================
  // clock, cycle counters, hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_cyc <= rst_i ? 0 : n_cyc + (instr_cycle_o ? 1 : 0);
    n_clk <= n_clk + 1;
    if (n_clk == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  // ==========================================================================
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task wait_until(input logic [PC_W-1:0] p);
    while (pmem_addr_o !== p) @(posedge clk_i);
  endtask
  task finish_test();
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // program, expectations and checks
  initial begin
    #1;
    k1 = 8'($random(seed));
    k2 = 8'($random(seed));
    k3 = 8'($random(seed));
    k4 = 8'($random(seed));
    bank = 6'($random(seed));
    s2 = {1'b0, k1} + {1'b0, k2};
    dc2 = ({1'b0, k1[3:0]} + {1'b0, k2[3:0]}) > 5'h0F;
    a3 = s2[7:0] & k3;
    fa = {3'h0, bank, 7'h10};
    fm = k4 & (fa[7:0] ^ 8'hA5);
    PM.rom[0] = {6'h3E, k1};
    PM.rom[1] = {6'h3E, k2};
    PM.rom[2] = {6'h39, k3};
    PM.rom[3] = 14'h0065;
    PM.rom[4] = 14'h317F;
    PM.rom[5] = 14'h001E;
    PM.rom[6] = 14'h3105;
    PM.rom[7] = 14'h0010;
    PM.rom[8] = 14'h3FBE;
    PM.rom[9] = 14'h280C;
    PM.rom[10] = 14'h3EFF;
    PM.rom[11] = 14'h3EFF;
    PM.rom[12] = 14'h2014;
    PM.rom[13] = 14'h0590;
    PM.rom[14] = 14'h0064;
    PM.rom[15] = 14'h0063;
    PM.rom[16] = 14'h2018;
    PM.rom[17] = 14'h33FF;
    PM.rom[20] = {6'h34, k4};
    PM.rom[24] = 14'h0009;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(WB_BANK, 1'b1, {26'h0, bank});
    wb(WB_BANK, 1'b0, 32'h0);
    chk(q, {26'h0, bank});
    wb(8'hF0, 1'b1, 32'hFFFFFFFF);
    wb(8'hF0, 1'b0, 32'h0);
    chk(q, 32'h0);
    wait_until(15'h000E);
    chk(n_cyc, 32'd16);
    while (sleep_o !== 1'b1) @(posedge clk_i);
    wake_i <= 1'b1;
    while (sleep_o !== 1'b0) @(posedge clk_i);
    wake_i <= 1'b0;
    wait_until(15'h0011);
    wb(WB_STATUS, 1'b0, 32'h0);
    chk(q, {17'h0, 4'b1001, fm == 8'h00, dc2, s2[8], k4});
    wb(WB_POINTERS, 1'b0, 32'h0);
    chk(q, 32'h00000006);
    wb(WB_DIR_BASE + 8'h14, 1'b0, 32'h0);
    chk(q, {24'h0, a3});
    wb(WB_DIR_BASE + 8'h10, 1'b0, 32'h0);
    chk(q, 32'h000000FF);
    wb(WB_PC, 1'b0, 32'h0);
    chk(q, 32'h00000011);
    chk({24'h0, PM.ram[16'hFFFF]}, {24'h0, a3});
    chk({24'h0, PM.ram[16'h0004]}, 32'h000000A3);
    chk({24'h0, PM.ram[fa]}, {24'h0, fm});
    chk({31'h0, gie_o}, 32'h1);
    PM.rom[17] = 14'h0001;
    while (soft_reset_o !== 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    chk({31'h0, gie_o}, 32'h0);
    finish_test();
  end
endmodule

//--- verif/cid_core_sva.sv
// port assertions for the decoder core
`timescale 1ns/10ps
module cid_core_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [cid_pkg::PC_W-1:0] pmem_addr_o,
  input wire logic data_re_o,
  input wire logic data_we_o,
  input wire logic sleep_o,
  input wire logic gie_o,
  input wire logic wdt_clear_o,
  input wire logic soft_reset_o,
  input wire logic instr_cycle_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  import cid_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // instruction cycle framing
  sequence s_quiet3;
    !instr_cycle_o [*3];
  endsequence
  sequence s_no_write;
    !data_we_o [*3];
  endsequence
  chk_cycle_period: assert property (instr_cycle_o |=> s_quiet3 ##1 instr_cycle_o)
    else $error("instruction cycle pulse spacing wrong");
  chk_pc_holds: assert property ($changed(pmem_addr_o) |=> $stable(pmem_addr_o) [*3])
    else $error("fetch address held less than one instruction cycle");
  chk_pc_at_boundary: assert property ($changed(pmem_addr_o) |-> instr_cycle_o)
    else $error("fetch address moved off a cycle boundary");
  chk_read_slot: assert property (data_re_o |-> ##2 instr_cycle_o)
    else $error("data read outside its slot");
  chk_write_slot: assert property (data_we_o |-> instr_cycle_o ##1 s_no_write)
    else $error("data write outside its slot");
  // ==========================================================================
  // inherent operations and bus acknowledge
  chk_kick_pulse: assert property (wdt_clear_o |-> instr_cycle_o ##1 !wdt_clear_o)
    else $error("watchdog clear pulse malformed");
  chk_standby_kick: assert property ($rose(sleep_o) |-> wdt_clear_o)
    else $error("standby entered without watchdog clear");
  chk_soft_reset_pc: assert property (soft_reset_o |-> ##[0:4] (pmem_addr_o == 15'h0000 && !gie_o))
    else $error("soft reset did not restart the program");
  chk_gie_boundary: assert property ($rose(gie_o) |-> instr_cycle_o)
    else $error("interrupt enable rose off a cycle boundary");
  chk_wb_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not a single pulse");
endmodule
bind cid_core cid_core_sva u_chk (.clk_i, .rst_i, .pmem_addr_o, .data_re_o, .data_we_o, .sleep_o, .gie_o,
  .wdt_clear_o, .soft_reset_o, .instr_cycle_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

//--- verif/cid_mem_model.sv
// program rom and data ram standing at the core's memory ports
`timescale 1ns/10ps
module cid_mem_model (
  input wire logic clk_i,
  input wire logic [cid_pkg::PC_W-1:0] pmem_addr_i,
  output logic [cid_pkg::IR_W-1:0] pmem_data_o,
  input wire logic [cid_pkg::DA_W-1:0] data_addr_i,
  input wire logic data_re_i,
  input wire logic data_we_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] data_rdata_o
);
  import cid_pkg::*;
  logic [IR_W-1:0] rom [0:255];
  logic [7:0] ram [0:65535];
  // ==========================================================================
  // contents at start: empty program, ram filled with a known pattern
  initial begin
    for (int i = 0; i < 256; i++) rom[i] = 14'h0000;
    for (int i = 0; i < 65536; i++) ram[i] = i[7:0] ^ 8'hA5;
    data_rdata_o = 8'h00;
  end
  // ==========================================================================
  // instruction word follows the fetch address so it is settled when latched
  assign pmem_data_o = rom[pmem_addr_i[7:0]];
  // ==========================================================================
  // one-clock synchronous data reads; read data is junk outside its slot
  always @(posedge clk_i) begin
    if (data_we_i) ram[data_addr_i] <= data_wdata_i;
    data_rdata_o <= data_re_i ? ram[data_addr_i] : ~data_rdata_o;
  end
endmodule
